//--- bench/cib_bus_partner.sv
// Bus-side model: memory and ports that answer reads, take writes and stretch cycles.
`timescale 1ns/10ps
`default_nettype none
module cib_bus_partner import cib_pkg::*; (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire cib_bus_t bus,
  input wire logic slow,
  output logic [7:0] ad_i,
  output logic ready,
  output logic [7:0] last_wr
);
  // ****************************************************************
  // Address latch, read data and wait stretching
  // ****************************************************************
  logic [7:0] adr_lat_r;
  logic [7:0] junk_r;
  logic [2:0] scnt_r;
  logic strobe_on;
  logic rd_on;
  assign rd_on = (bus.strobe_oe && !bus.rd_n) || !bus.irq_ack_strobe_n;
  assign strobe_on = rd_on || (bus.strobe_oe && !bus.wr_n);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      adr_lat_r <= 8'h00;
      junk_r <= 8'h00;
      scnt_r <= 3'h0;
      last_wr <= 8'h00;
    end else begin
      junk_r <= junk_r + 8'h5b;
      if (bus.ale) begin
        adr_lat_r <= bus.ad_o;
      end
      if (!strobe_on) begin
        scnt_r <= 3'h0;
      end else if (scnt_r != 3'h7) begin
        scnt_r <= scnt_r + 3'h1;
      end
      if (bus.strobe_oe && !bus.wr_n && bus.ad_oe) begin
        last_wr <= bus.ad_o;
      end
    end
  end
  // Outside a read the lines show a pattern that changes every cycle, never stale data.
  assign ad_i = rd_on ? (adr_lat_r ^ 8'ha5) : junk_r;
  assign ready = !slow || (scnt_r >= 3'h3);
endmodule : cib_bus_partner
`default_nettype wire

//--- bench/tb_cpu_interrupt_and_bus_cycles.sv
// Self-checking testbench of the interrupt and bus cycle block.
`timescale 1ns/10ps
`default_nettype none
`include "cib_regs.svh"
module tb_cpu_interrupt_and_bus_cycles import cib_pkg::*;;
  logic clk_sys = 1'b0;
  logic nrst;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  cib_irq_t irq_in;
  logic hold_req;
  logic slow;
  logic [7:0] ad_i;
  logic ready;
  logic [7:0] last_wr;
  logic serial_in_pin;
  logic serial_out_pin;
  cib_bus_t bus;
  int n_mismatch = 0;
  int checked = 0;
  logic [31:0] seed = 32'h3982;
  logic [15:0] v;
  logic [2:0] em;
  logic es;
  logic [7:0] vecs [5] = '{8'h24, 8'h3c, 8'h34, 8'h2c, 8'h00};
  always #4 clk_sys = ~clk_sys;
  cib_core #(.DW(16)) dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_in(irq_in), .hold_req(hold_req), .ready(ready), .ad_i(ad_i),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .bus(bus));
  cib_bus_partner far_side (.clk_sys(clk_sys), .nrst(nrst), .bus(bus), .slow(slow),
    .ad_i(ad_i), .ready(ready), .last_wr(last_wr));
  // ****************************************************************
  // Shared tasks and expectations
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [2:0] exp_stat(input logic [2:0] k);
    case (k)
      3'h0: return 3'b011;
      3'h1, 3'h6: return 3'b010;
      3'h2: return 3'b001;
      3'h3: return 3'b110;
      3'h4: return 3'b101;
      default: return 3'b111;
    endcase
  endfunction : exp_stat
  function automatic logic [2:0] exp_strb(input logic [2:0] k);
    case (k)
      3'h0, 3'h1, 3'h3: return 3'b100;
      3'h2, 3'h4: return 3'b010;
      3'h5: return 3'b001;
      default: return 3'b000;
    endcase
  endfunction : exp_strb
  task automatic tally_and_finish;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t register got=%h exp=%h", $time, g, e);
    end
  endtask : chk_reg
  task automatic chk_bus(input logic [8:0] g, input logic [8:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t pins got=%h exp=%h", $time, g, e);
    end
  endtask : chk_bus
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // Ends on a rising edge so that the caller may drive inputs by non-blocking assignment.
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
    @(posedge clk_sys);
  endtask : rd
  task automatic irq_chk(input logic [3:0] ctl, input logic [8:0] e);
    logic [15:0] r = 16'h0000;
    // Inputs are seen two to three cycles after a pin change.
    repeat (4) @(posedge clk_sys);
    if (ctl != 4'h0) wr(`CIB_OFF_IRQ_CTRL, {12'h000, ctl});
    for (int i = 0; i < 6 && r[8] !== 1'b1; i++) rd(`CIB_OFF_IRQ_CTRL, r);
    chk_reg({7'h00, r[8], r[7:0] & {8{e[8]}}}, {7'h00, e});
  endtask : irq_chk
  task automatic run_cyc(input logic [2:0] k, input logic [15:0] a, input logic six);
    int st = 0;
    int nale = 0;
    int nrd = 0;
    int nwr = 0;
    int nack = 0;
    int el = (k == 3'h0 || k == 3'h5) ? (six ? 6 : 4) : 3;
    logic no_ale = (k == 3'h6);
    logic done = 1'b0;
    logic [7:0] d;
    seed = lfsr(seed);
    d = seed[7:0];
    wr(`CIB_OFF_CYC_ADDR, a);
    wr(`CIB_OFF_CYC_DATA, {8'h00, d});
    wr(`CIB_OFF_CYC_CTRL, {11'h000, six, no_ale, k});
    for (int i = 0; i < 60 && !done; i++) begin
      @(negedge clk_sys);
      if (bus.io_m_oe === 1'b1) begin
        st++;
        if (bus.ale === 1'b1) begin
          nale++;
          chk_bus({bus.ad_oe, bus.ad_o}, {1'b1, a[7:0]});
          chk_bus({6'h00, bus.io_m, bus.cycle_status1, bus.cycle_status0}, {6'h00, exp_stat(k)});
          chk_bus({6'h00, bus.rd_n, bus.wr_n, bus.irq_ack_strobe_n}, 9'h007);
          chk_bus({1'b0, bus.addr_hi}, {1'b0, (k == 3'h3 || k == 3'h4) ? a[7:0] : a[15:8]});
        end
        if (st > 3 && !slow) begin
          chk_bus({6'h00, bus.ad_oe, bus.cycle_status1, bus.cycle_status0}, 9'h003);
        end
        if (bus.strobe_oe === 1'b1 && bus.rd_n === 1'b0) nrd++;
        if (bus.strobe_oe === 1'b1 && bus.wr_n === 1'b0) nwr++;
        if (bus.irq_ack_strobe_n === 1'b0) nack++;
      end else if (st > 0) begin
        done = 1'b1;
      end
    end
    if (!done) begin
      n_mismatch++;
      tally_and_finish();
    end
    @(posedge clk_sys);
    chk_bus({8'h00, slow ? st > el : st == el}, 9'h001);
    chk_bus({5'h00, nale == (no_ale ? 0 : 1), nrd != 0, nwr != 0, nack != 0},
      {6'h01, exp_strb(k)});
    if (exp_strb(k) == 3'b100) begin
      rd(`CIB_OFF_CYC_DATA, v);
      chk_reg(v, {8'h00, a[7:0] ^ 8'ha5});
    end
    if (exp_strb(k) == 3'b010) chk_bus({1'b0, last_wr}, {1'b0, d});
  endtask : run_cyc
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    nrst = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    irq_in = '0;
    hold_req = 1'b0;
    slow = 1'b0;
    serial_in_pin = 1'b1;
    em = `CIB_RST_MASK;
    es = 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(`CIB_OFF_READ_MASK, v);
    chk_reg({11'h000, v[7], v[3:0]}, 16'h0017);
    chk_bus({8'h00, serial_out_pin}, 9'h000);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      serial_in_pin <= seed[9];
      wr(`CIB_OFF_SET_MASK, {8'h00, seed[7:6], 2'b00, seed[3:0]});
      if (seed[3]) em = seed[2:0];
      if (seed[6]) es = seed[7];
      rd(`CIB_OFF_READ_MASK, v);
      chk_reg({8'h00, v[7], 4'h0, v[2:0]}, {8'h00, seed[9], 4'h0, em});
      chk_bus({8'h00, serial_out_pin}, {8'h00, es});
    end
    for (int j = 0; j < 10; j++) begin
      seed = lfsr(seed);
      slow <= (j > 7);
      run_cyc(3'(j), seed[15:0], seed[16]);
    end
    slow <= 1'b0;
    hold_req <= 1'b1;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_bus({4'h0, bus.hlda, bus.addr_hi_oe, bus.ad_oe, bus.io_m_oe, bus.strobe_oe}, 9'h010);
    @(posedge clk_sys);
    hold_req <= 1'b0;
    wr(`CIB_OFF_SET_MASK, 16'h000f);
    irq_in.edge_restart_irq <= 1'b1;
    repeat (4) @(posedge clk_sys);
    irq_in.edge_restart_irq <= 1'b0;
    rd(`CIB_OFF_READ_MASK, v);
    chk_reg({15'h0000, v[6]}, 16'h0001);
    wr(`CIB_OFF_SET_MASK, 16'h0010);
    rd(`CIB_OFF_READ_MASK, v);
    chk_reg({15'h0000, v[6]}, 16'h0000);
    irq_in.level_restart_irq_low <= 1'b1;
    wr(`CIB_OFF_IRQ_CTRL, 16'h0001);
    irq_chk(4'h4, 9'h000);
    irq_in.trap <= 1'b1;
    irq_chk(4'h4, 9'h124);
    rd(`CIB_OFF_READ_MASK, v);
    chk_reg({15'h0000, v[3]}, 16'h0001);
    rd(`CIB_OFF_READ_MASK, v);
    chk_reg({15'h0000, v[3]}, 16'h0000);
    // The source keeps the non-maskable line high past its acknowledge.
    wr(`CIB_OFF_IRQ_CTRL, 16'h0001);
    irq_chk(4'h4, 9'h000);
    wr(`CIB_OFF_IRQ_CTRL, 16'h0002);
    rd(`CIB_OFF_READ_MASK, v);
    chk_reg({15'h0000, v[3]}, 16'h0000);
    irq_in.trap <= 1'b0;
    wr(`CIB_OFF_SET_MASK, 16'h0008);
    irq_in <= 5'h1f;
    for (int i = 0; i < 5; i++) begin
      wr(`CIB_OFF_IRQ_CTRL, 16'h0001);
      irq_chk(4'h4, {1'b1, vecs[i]});
      irq_chk(4'h4, 9'h000);
      if (i != 1 && i != 4) irq_in <= irq_in & ~(5'h10 >> i);
    end
    irq_in <= 5'h00;
    wr(`CIB_OFF_IRQ_CTRL, 16'h0001);
    wr(`CIB_OFF_CYC_CTRL, 16'h0020);
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_bus({4'h0, bus.strobe_oe, bus.ad_oe, bus.addr_hi_oe, bus.cycle_status1,
      bus.cycle_status0}, 9'h000);
    @(posedge clk_sys);
    rd(`CIB_OFF_CYC_CTRL, v);
    chk_reg(v, 16'h000d);
    irq_in.level_restart_irq_low <= 1'b1;
    irq_chk(4'h0, 9'h12c);
    // Leave the edge flop set so that the reset below has something to clear.
    irq_in <= 5'h08;
    repeat (4) @(posedge clk_sys);
    irq_in <= 5'h00;
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(`CIB_OFF_READ_MASK, v);
    chk_reg({12'h000, v[6], v[2:0]}, 16'h0007);
    tally_and_finish();
  end
endmodule : tb_cpu_interrupt_and_bus_cycles
`default_nettype wire

//--- logic/cib_core.sv
// Interrupt recognition and multiplexed bus machine-cycle sequencer.
//
// What this block does
// [RQ1] T1 drives low address on shared lines, pulses address strobe, then data.
// [RQ2] Bus request, ready and all interrupt inputs pass two-flop synchronisers.
// [RQ3] Maskable restarts need global enable and a clear mask; restart vectors.
// [RQ4] Vectors: 24h non-maskable, 3ch edge, 34h high level, 2ch low level.
// [RQ5] Non-maskable restart ignores global enable and every mask.
// [RQ6] Two lower restarts are level sensed; the highest one is rising edge.
// [RQ7] Edge request flop set by edge, cleared by service, set-mask or reset.
// [RQ8] Edge request flop still sets while that input is masked.
// [RQ9] Restart masks change only by set-mask or reset.
// [RQ10] Fixed priority: non-maskable, edge, high level, low level, general.
// [RQ11] Priority ignores which service routine currently runs.
// [RQ12] Source holds non-maskable input high until acknowledged.
// [RQ13] Non-maskable input is recognised again only after low then high.
// [RQ14] Any acceptance clears global enable until enable-irq instruction.
// [RQ15] Non-maskable saves enable; first read-mask reports it, later ones current.
// [RQ16] Read-mask captures serial input pin; set-mask updates serial output pin.
// [RQ17] I/O cycles copy port address onto upper lines and low shared lines.
// [RQ18] Status and select valid from T1; strobes only during data transfer.
// [RQ19] Cycles last three states, fetch four or six; wait and hold extend.
// [RQ20] Select/status/strobe encoding per machine cycle type.
// [RQ21] Idle cycles drive no strobe; double-add idle has no address strobe.
// [RQ22] Address strobe only in T1; T4-T6 status 11, lines float; float in hold.
// [RQ23] General and level inputs sampled at next-to-last cycle, halt and hold.
// [RQ24] Set-mask layout: masks 2:0, enable 3, clear edge 4, serial 6 and 7.
`timescale 1ns/10ps
`default_nettype none
`include "cib_regs.svh"
module cib_core import cib_pkg::*; #(
  parameter int DW = 16
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  input wire cib_irq_t irq_in,
  input wire logic hold_req,
  input wire logic ready,
  input wire logic [7:0] ad_i,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output cib_bus_t bus
);
  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic [2:0] cyc_code(input cib_cyc_t k);
    unique case (k)
      CYC_OF: cyc_code = 3'h3;
      CYC_MR: cyc_code = 3'h2;
      CYC_MW: cyc_code = 3'h1;
      CYC_IOR: cyc_code = 3'h6;
      CYC_IOW: cyc_code = 3'h5;
      CYC_INA: cyc_code = 3'h7;
      CYC_BI_DAD: cyc_code = 3'h2;
      CYC_BI_RST: cyc_code = 3'h7;
    endcase
  endfunction : cyc_code

  function automatic cib_src_t pick(input logic [4:0] p);
    if (p[4]) pick = SRC_TRAP;
    else if (p[3]) pick = SRC_R75;
    else if (p[2]) pick = SRC_R65;
    else if (p[1]) pick = SRC_R55;
    else if (p[0]) pick = SRC_GENERAL_IRQ_INPUT;
    else pick = SRC_NONE;
  endfunction : pick

  function automatic logic [7:0] vec_of(input cib_src_t s);
    unique case (s)
      SRC_TRAP: vec_of = `CIB_VEC_TRAP;
      SRC_R75: vec_of = `CIB_VEC_R75;
      SRC_R65: vec_of = `CIB_VEC_R65;
      SRC_R55: vec_of = `CIB_VEC_R55;
      default: vec_of = `CIB_VEC_NONE;
    endcase
  endfunction : vec_of

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int NS = 7;
  logic [NS-1:0] raw;
  logic [NS-1:0] sync1_r;
  logic [NS-1:0] sync2_r;
  logic [NS-1:0] prev_r;
  assign raw = {hold_req, ready, irq_in};
  for (genvar i = 0; i < NS; i++) begin : g_sync
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        sync1_r[i] <= 1'b0;
        sync2_r[i] <= 1'b0;
        prev_r[i] <= 1'b0;
      end else begin
        sync1_r[i] <= raw[i]; // RQ2
        sync2_r[i] <= sync1_r[i];
        prev_r[i] <= sync2_r[i];
      end
    end
  end
  logic hold_s, ready_s, trap_s, r75_s, r65_s, r55_s, general_irq_input_s, trap_rise, r75_rise;
  assign {hold_s, ready_s, trap_s, r75_s, r65_s, r55_s, general_irq_input_s} = sync2_r;
  assign trap_rise = trap_s & ~prev_r[4];
  assign r75_rise = r75_s & ~prev_r[3];

  // ****************************************************************
  // Register writes and interrupt state
  // ****************************************************************
  cib_state_t st_r;
  logic [2:0] mask_r;
  logic ie_r, saved_ie_r, trap_flag_r, r75_ff_r, trap_arm_r;
  logic acc_vld_r;
  logic [7:0] acc_vec_r;
  logic wr_sim, wr_irq, rd_rim, rd_irq, sample, accept;
  logic [4:0] pend;
  cib_src_t win;
  assign wr_sim = reg_wr && reg_addr == `CIB_OFF_SET_MASK;
  assign wr_irq = reg_wr && reg_addr == `CIB_OFF_IRQ_CTRL;
  assign rd_rim = reg_rd && reg_addr == `CIB_OFF_READ_MASK;
  assign rd_irq = reg_rd && reg_addr == `CIB_OFF_IRQ_CTRL;
  // Level inputs are looked at only here, so a short level pulse between samples is missed.
  assign sample = (wr_irq && reg_wdata[`CIB_IRQ_SAMPLE]) || st_r == ST_HALT
      || st_r == ST_HOLD; // RQ23
  assign pend = {trap_arm_r & trap_s, // RQ5
      ie_r & r75_ff_r & ~mask_r[2], ie_r & r65_s & ~mask_r[1], // RQ3 RQ6
      ie_r & r55_s & ~mask_r[0], ie_r & general_irq_input_s};
  assign win = pick(pend); // RQ10 RQ11
  assign accept = sample && win != SRC_NONE;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mask_r <= `CIB_RST_MASK;
    end else if (wr_sim && reg_wdata[`CIB_SIM_MSE]) begin
      mask_r <= reg_wdata[2:0]; // RQ9 RQ24
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      serial_out_pin <= 1'b0;
    end else if (wr_sim && reg_wdata[`CIB_SIM_SOE]) begin
      serial_out_pin <= reg_wdata[`CIB_SIM_SOD]; // RQ16
    end
  end

  // The edge flop is fed regardless of the mask; a new edge beats any clear.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r75_ff_r <= 1'b0;
    end else if (r75_rise) begin
      r75_ff_r <= 1'b1; // RQ7 RQ8
    end else if ((accept && win == SRC_R75) || (wr_sim && reg_wdata[`CIB_SIM_CLR75])) begin
      r75_ff_r <= 1'b0; // RQ7
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      trap_arm_r <= 1'b0;
    end else if (accept && win == SRC_TRAP) begin
      trap_arm_r <= 1'b0; // RQ13
    end else if (trap_rise) begin
      trap_arm_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ie_r <= 1'b0;
    end else if (accept) begin
      ie_r <= 1'b0; // RQ14
    end else if (wr_irq && reg_wdata[`CIB_IRQ_EI]) begin
      ie_r <= 1'b1;
    end else if (wr_irq && reg_wdata[`CIB_IRQ_DI]) begin
      ie_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      trap_flag_r <= 1'b0;
      saved_ie_r <= 1'b0;
    end else if (accept) begin
      trap_flag_r <= win == SRC_TRAP; // RQ15
      saved_ie_r <= ie_r;
    end else if (rd_rim) begin
      trap_flag_r <= 1'b0; // RQ15
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      acc_vld_r <= 1'b0;
      acc_vec_r <= `CIB_VEC_NONE;
    end else if (accept) begin
      acc_vld_r <= 1'b1;
      acc_vec_r <= vec_of(win); // RQ3 RQ4
    end else if (rd_irq) begin
      acc_vld_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Machine cycle sequencer
  // ****************************************************************
  cib_cyc_t kind_r;
  logic no_ale_r, six_r, halt_r, go_r, fetch_like, xfer;
  logic [1:0] t4_cnt_r;
  logic [15:0] addr_r;
  logic [7:0] wdat_r, rdat_r;
  logic wr_ctl;
  assign wr_ctl = reg_wr && reg_addr == `CIB_OFF_CYC_CTRL && !go_r && st_r == ST_IDLE;
  assign fetch_like = kind_r == CYC_OF || kind_r == CYC_INA;
  assign xfer = kind_r != CYC_BI_DAD && kind_r != CYC_BI_RST;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      kind_r <= CYC_OF;
      no_ale_r <= 1'b0;
      six_r <= 1'b0;
    end else if (wr_ctl) begin
      kind_r <= cib_cyc_t'(reg_wdata[2:0]);
      no_ale_r <= reg_wdata[`CIB_CTL_NO_ALE];
      six_r <= reg_wdata[`CIB_CTL_SIX];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      go_r <= 1'b0;
      halt_r <= 1'b0;
    end else begin
      if (wr_ctl && !reg_wdata[`CIB_CTL_HALT]) go_r <= 1'b1;
      else if (st_r == ST_T1) go_r <= 1'b0;
      if (wr_ctl && reg_wdata[`CIB_CTL_HALT]) halt_r <= 1'b1;
      else if (accept) halt_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addr_r <= 16'h0000;
      wdat_r <= 8'h00;
    end else if (reg_wr && reg_addr == `CIB_OFF_CYC_ADDR) begin
      addr_r <= reg_wdata[15:0];
    end else if (reg_wr && reg_addr == `CIB_OFF_CYC_DATA) begin
      wdat_r <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdat_r <= 8'h00;
    end else if (st_r == ST_T3 && xfer && cyc_code(kind_r) != 3'h1
        && cyc_code(kind_r) != 3'h5) begin
      rdat_r <= ad_i;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_RESET;
      t4_cnt_r <= 2'h0;
    end else begin
      unique case (st_r)
        ST_RESET: st_r <= ST_IDLE;
        ST_IDLE: begin
          if (hold_s) st_r <= ST_HOLD; // RQ19
          else if (halt_r) st_r <= ST_HALT;
          else if (go_r) st_r <= ST_T1;
        end
        ST_T1: st_r <= ST_T2; // RQ1
        ST_T2: st_r <= (xfer && !ready_s) ? ST_TWAIT : ST_T3; // RQ19
        ST_TWAIT: if (ready_s) st_r <= ST_T3;
        ST_T3: begin
          if (fetch_like) begin
            st_r <= ST_T4;
            t4_cnt_r <= six_r ? `CIB_T4_EXTRA : 2'h0; // RQ19
          end else begin
            st_r <= ST_IDLE;
          end
        end
        ST_T4: begin
          if (t4_cnt_r == 2'h0) st_r <= ST_IDLE;
          else t4_cnt_r <= t4_cnt_r - 2'h1;
        end
        ST_HALT: begin
          if (hold_s) st_r <= ST_HOLD;
          else if (accept) st_r <= ST_IDLE;
        end
        ST_HOLD: if (!hold_s) st_r <= halt_r ? ST_HALT : ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Bus pins
  // ****************************************************************
  logic in_xfer, is_io;
  logic [2:0] code;
  assign code = cyc_code(kind_r);
  assign is_io = kind_r == CYC_IOR || kind_r == CYC_IOW;
  assign in_xfer = xfer && (st_r == ST_T2 || st_r == ST_TWAIT || st_r == ST_T3);

  always_comb begin
    bus = '0;
    bus.rd_n = 1'b1;
    bus.wr_n = 1'b1;
    bus.irq_ack_strobe_n = 1'b1;
    bus.hlda = st_r == ST_HOLD;
    unique case (st_r)
      ST_T1, ST_T2, ST_TWAIT, ST_T3: begin
        bus.addr_hi = is_io ? addr_r[7:0] : addr_r[15:8]; // RQ17
        bus.addr_hi_oe = 1'b1;
        bus.io_m_oe = 1'b1;
        bus.strobe_oe = 1'b1;
        {bus.io_m, bus.cycle_status1, bus.cycle_status0} = code; // RQ18 RQ20
        if (st_r == ST_T1) begin
          bus.ad_o = addr_r[7:0]; // RQ1
          bus.ad_oe = 1'b1;
          bus.ale = !no_ale_r; // RQ21 RQ22
        end else if (code == 3'h1 || code == 3'h5) begin
          bus.ad_o = wdat_r;
          bus.ad_oe = 1'b1;
        end
        if (in_xfer) begin
          bus.rd_n = !(kind_r == CYC_OF || kind_r == CYC_MR || kind_r == CYC_IOR);
          bus.wr_n = !(kind_r == CYC_MW || kind_r == CYC_IOW); // RQ18
          bus.irq_ack_strobe_n = kind_r != CYC_INA; // RQ21
        end
      end
      ST_T4: begin
        bus.addr_hi = addr_r[15:8];
        bus.addr_hi_oe = 1'b1;
        bus.io_m_oe = 1'b1;
        bus.strobe_oe = 1'b1;
        bus.io_m = kind_r == CYC_INA;
        bus.cycle_status1 = 1'b1; // RQ22
        bus.cycle_status0 = 1'b1;
      end
      ST_IDLE: bus.strobe_oe = 1'b1;
      ST_RESET, ST_HALT, ST_HOLD: ; // RQ21 RQ22
    endcase
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        unique case (reg_addr)
          `CIB_OFF_CYC_CTRL: reg_rdata[3:0] <= {go_r || st_r != ST_IDLE,
              st_r == ST_HALT, st_r == ST_HOLD, halt_r};
          `CIB_OFF_CYC_ADDR: reg_rdata[15:0] <= addr_r;
          `CIB_OFF_CYC_DATA: reg_rdata[7:0] <= rdat_r;
          `CIB_OFF_READ_MASK: reg_rdata[7:0] <= {serial_in_pin, // RQ16
              r75_ff_r, r65_s, r55_s, trap_flag_r ? saved_ie_r : ie_r, mask_r}; // RQ15
          `CIB_OFF_IRQ_CTRL: reg_rdata[8:0] <= {acc_vld_r, acc_vec_r};
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_ale_t1;
    bus.ale |-> st_r == ST_T1 ##1 !bus.ale && bus.ad_oe == (code == 3'h1 || code == 3'h5);
  endproperty
  a_ale_t1: assert property (p_ale_t1) else $error("address strobe outside T1"); // RQ1

  property p_strobe_late;
    !bus.rd_n |-> $past(st_r) != ST_IDLE && st_r != ST_T1 && st_r != ST_T4;
  endproperty
  a_strobe_late: assert property (p_strobe_late) else $error("read strobe out of phase"); // RQ18

  property p_ie_clear;
    accept |=> !ie_r;
  endproperty
  a_ie_clear: assert property (p_ie_clear) else $error("enable not cleared"); // RQ14

  property p_trap_wins;
    sample && trap_arm_r && trap_s |=> acc_vld_r && acc_vec_r == `CIB_VEC_TRAP;
  endproperty
  a_trap_wins: assert property (p_trap_wins) else $error("trap not taken"); // RQ5

  property p_mask_only_sim;
    !(wr_sim && reg_wdata[`CIB_SIM_MSE]) |=> $stable(mask_r);
  endproperty
  a_mask_only_sim: assert property (p_mask_only_sim) else $error("mask moved"); // RQ9

  property p_r75_masked;
    r75_rise && mask_r[2] |=> r75_ff_r;
  endproperty
  a_r75_masked: assert property (p_r75_masked) else $error("edge lost while masked"); // RQ8

  property p_prio;
    accept && pend[4] == 1'b0 && pend[3] |=> acc_vec_r == `CIB_VEC_R75;
  endproperty
  a_prio: assert property (p_prio) else $error("priority order broken"); // RQ10

  property p_io_copy;
    st_r == ST_T1 && is_io |-> bus.addr_hi == bus.ad_o;
  endproperty
  a_io_copy: assert property (p_io_copy) else $error("port address not copied"); // RQ17

  property p_three_states;
    st_r == ST_T1 && !fetch_like && ready_s ##1 ready_s |-> ##2 st_r == ST_IDLE;
  endproperty
  a_three_states: assert property (p_three_states) else $error("cycle length wrong"); // RQ19

  property p_trap_rearm;
    accept && win == SRC_TRAP ##1 trap_s [*2] |-> !pend[4];
  endproperty
  a_trap_rearm: assert property (p_trap_rearm) else $error("trap retaken"); // RQ13

  c_fetch: cover property (st_r == ST_T4 ##1 st_r == ST_IDLE);
  c_wait: cover property (st_r == ST_TWAIT ##1 st_r == ST_T3);
  c_hold: cover property (st_r == ST_HOLD);
  c_trap_rim: cover property (trap_flag_r && rd_rim);
endmodule : cib_core
`default_nettype wire

//--- logic/cib_pkg.sv
// Types shared by the interrupt and bus cycle block.
`default_nettype none
package cib_pkg;
  typedef enum logic [2:0] {
    CYC_OF, CYC_MR, CYC_MW, CYC_IOR, CYC_IOW, CYC_INA, CYC_BI_DAD, CYC_BI_RST
  } cib_cyc_t;
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_T1, ST_T2, ST_TWAIT, ST_T3, ST_T4, ST_HALT, ST_HOLD
  } cib_state_t;
  typedef enum logic [2:0] {
    SRC_NONE, SRC_TRAP, SRC_R75, SRC_R65, SRC_R55, SRC_GENERAL_IRQ_INPUT
  } cib_src_t;
  typedef struct packed {
    logic trap;
    logic edge_restart_irq;
    logic level_restart_irq_high;
    logic level_restart_irq_low;
    logic general_irq_input;
  } cib_irq_t;
  typedef struct packed {
    logic [7:0] addr_hi;
    logic addr_hi_oe;
    logic [7:0] ad_o;
    logic ad_oe;
    logic ale;
    logic io_m;
    logic io_m_oe;
    logic cycle_status1;
    logic cycle_status0;
    logic rd_n;
    logic wr_n;
    logic strobe_oe;
    logic irq_ack_strobe_n;
    logic hlda;
  } cib_bus_t;
endpackage : cib_pkg
`default_nettype wire

//--- logic/cib_regs.svh
// Register offsets, field positions, reset values and vectors of the interrupt/bus block.
`ifndef CIB_REGS_SVH
`define CIB_REGS_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define CIB_OFF_CYC_CTRL 4'h0
`define CIB_OFF_CYC_ADDR 4'h1
`define CIB_OFF_CYC_DATA 4'h2
`define CIB_OFF_SET_MASK 4'h3
`define CIB_OFF_READ_MASK 4'h4
`define CIB_OFF_IRQ_CTRL 4'h5
// ****************************************************************
// Field positions
// ****************************************************************
`define CIB_CTL_NO_ALE 3
`define CIB_CTL_SIX 4
`define CIB_CTL_HALT 5
`define CIB_SIM_MSE 3
`define CIB_SIM_CLR75 4
`define CIB_SIM_SOE 6
`define CIB_SIM_SOD 7
`define CIB_IRQ_EI 0
`define CIB_IRQ_DI 1
`define CIB_IRQ_SAMPLE 2
// ****************************************************************
// Reset values, extra T4 states and restart vectors
// ****************************************************************
`define CIB_RST_MASK 3'h7
`define CIB_T4_EXTRA 2'h2
`define CIB_VEC_TRAP 8'h24
`define CIB_VEC_R75 8'h3c
`define CIB_VEC_R65 8'h34
`define CIB_VEC_R55 8'h2c
`define CIB_VEC_NONE 8'h00
`endif
